// [logic/shc_map.svh]
// Constant map of the standby, halt and stop controller.
`ifndef SHC_MAP_SVH
`define SHC_MAP_SVH
`define SHC_STAB_SEL_W 3
`define SHC_STAB_CNT_W 8
`define SHC_STAB_SEL_RST 3'h7
`define SHC_STAB_UNIT_NS 800
`define SHC_CLK_NS 50
`define SHC_STAB_UNIT_CYC ((`SHC_STAB_UNIT_NS + `SHC_CLK_NS - 1) / `SHC_CLK_NS)
`define SHC_PRE_W 8
`endif

// [logic/shc_pkg.sv]
// Types of the standby, halt and stop controller.
package shc_pkg;
   typedef enum logic [3:0] {
      SHC_RUN = 4'h1,
      SHC_HALT = 4'h2,
      SHC_STOP = 4'h4,
      SHC_WAIT = 4'h8
   } shc_mode_t;
endpackage

// [logic/shc_standby_ctrl.sv]
// Standby controller: halt, stop, stabilization wait, regulator and reset pin.
//
// Functional notes
// - Halt instruction stops processor clock.
// - Running high-speed and subsystem oscillators keep oscillating during halt.
// - Interrupt releases halt without stabilization wait.
// - Stop instruction on the main clock halts both high-speed oscillators.
// - Interrupt releases stop mode.
// - Crystal clock selected: wait after stop.
// - Registers, flags, memory retained in standby.
// - Port latches and buffers held unchanged.
// - Halt accepted on main or subsystem clock.
// - Option setting keeps or stops low-speed oscillator.
// - Low-consumption regulator in reset, stop outside debug, sub-only.
// - Counter status and time select registers.
// - Reset-output pin low during reset.
`timescale 1ns/10ps
`default_nettype none
`include "shc_map.svh"
module shc_standby_ctrl
   import shc_pkg::*;
#(
   parameter int PRE_CYC = `SHC_STAB_UNIT_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Processor requests and state
   input wire logic haltExec,
   input wire logic stopExec,
   input wire logic intReq,
   input wire logic cpuOnSubClock,
   input wire logic debugActive,
   // Clock selection and option bits
   input wire logic crystalSelected,
   input wire logic hsExtRunning,
   input wire logic hsIntRunning,
   input wire logic subRunning,
   input wire logic lowSpeedKeepOpt,
   // Stabilization time select, written by software
   input wire logic stabSelWrite,
   input wire logic [`SHC_STAB_SEL_W-1:0] stabSelData,
   // Reset-output port latch value, written by software
   input wire logic resetPinLatchWrite,
   input wire logic resetPinLatchData,
   // Outputs
   output logic cpuClockEnable,
   output logic hsExtOscEnable,
   output logic hsIntOscEnable,
   output logic subOscEnable,
   output logic lowSpeedOscEnable,
   output logic regulatorLowMode,
   output logic [`SHC_STAB_CNT_W-1:0] osc_stab_counter_status,
   output logic [`SHC_STAB_SEL_W-1:0] osc_stab_time_select,
   output logic reset_output_port_pin,
   output logic standbyHold,
   output logic [3:0] modeState
);
   import shc_pkg::*;

   typedef struct packed {
      shc_mode_t mode;
      logic [`SHC_STAB_CNT_W-1:0] stabCnt;
      logic [`SHC_PRE_W-1:0] pre;
      logic [`SHC_STAB_SEL_W-1:0] stabSel;
      logic hsExt;
      logic hsInt;
      logic sub;
      logic lowSpd;
      logic cpuEn;
      logic regLow;
      logic pinLatch;
      logic pinOut;
      logic hold;
   } shc_state_t;

   shc_state_t st_r;
   shc_state_t st_nxt;
   logic [`SHC_STAB_CNT_W-1:0] target;
   logic tick;

   // Selected wait length: 2^(sel+1)-1 units, saturating in the counter width.
   // A nine-bit shift keeps the largest selection from wrapping to zero.
   assign target = `SHC_STAB_CNT_W'((9'h002 << st_r.stabSel) - 9'h001);
   // One tick per stabilization unit; the unit is a whole number of clock cycles.
   // The prescaler is cleared on release from stop, so the first unit is never short.
   assign tick = (st_r.pre == `SHC_PRE_W'(PRE_CYC - 1));

   always_comb begin
      st_nxt = st_r;
      st_nxt.pre = tick ? '0 : st_r.pre + 1'b1;
      if (stabSelWrite) begin
         st_nxt.stabSel = stabSelData;
      end
      // The latch is kept out of reset on purpose: a high level written before
      // reset survives it, so the pin can mimic a processor reset output.
      if (resetPinLatchWrite) begin
         st_nxt.pinLatch = resetPinLatchData;
      end
      st_nxt.pinOut = st_r.pinLatch;
      case (st_r.mode)
         SHC_RUN: begin
            // Halt is checked first, so it wins when both instructions coincide.
            // halt any clock
            if (haltExec) begin
               st_nxt.mode = SHC_HALT;
               st_nxt.cpuEn = 1'b0;
            // A stop on the subsystem clock is dropped with no flag, since
            // software is required never to issue it.
            // stop on main only
            end else if (stopExec && !cpuOnSubClock) begin
               st_nxt.mode = SHC_STOP;
               st_nxt.cpuEn = 1'b0;
               st_nxt.hsExt = 1'b0;
               st_nxt.hsInt = 1'b0;
               st_nxt.stabCnt = '0;
            end
         end
         SHC_HALT: begin
            if (intReq) begin
               st_nxt.mode = SHC_RUN;
               st_nxt.cpuEn = 1'b1;
            end
         end
         SHC_STOP: begin
            // interrupt release
            // The internal oscillator always restarts; the crystal when selected or when hsExtRunning is set.
            if (intReq) begin
               st_nxt.hsExt = hsExtRunning;
               st_nxt.hsInt = 1'b1;
               st_nxt.pre = '0;
               if (crystalSelected) begin
                  st_nxt.hsExt = 1'b1;
                  st_nxt.mode = SHC_WAIT;
               end else begin
                  st_nxt.mode = SHC_RUN;
                  st_nxt.cpuEn = 1'b1;
               end
            end
         end
         SHC_WAIT: begin
            // count to selected time
            // The count is not cleared on release, so it shows the elapsed units.
            if (st_r.stabCnt >= target) begin
               st_nxt.mode = SHC_RUN;
               st_nxt.cpuEn = 1'b1;
            end else if (tick) begin
               st_nxt.stabCnt = st_r.stabCnt + 1'b1;
            end
         end
         default: begin
            st_nxt.mode = SHC_RUN;
            st_nxt.cpuEn = 1'b1;
         end
      endcase
      if (st_r.mode != SHC_STOP && st_nxt.mode != SHC_STOP) begin
         st_nxt.sub = subRunning;
         if (st_r.mode == SHC_RUN) begin
            st_nxt.hsExt = hsExtRunning;
            st_nxt.hsInt = hsIntRunning;
         end
      end
      // option keeps low-speed
      // The stabilization wait counts as standby, so the option governs it too.
      st_nxt.lowSpd = (st_nxt.mode == SHC_RUN) || lowSpeedKeepOpt;
      // regulator low conditions
      // Taken from the next state, so the regulator moves on the same edge as the mode.
      // Debug operation keeps the normal output during stop.
      st_nxt.regLow = (st_nxt.mode == SHC_STOP && !debugActive) ||
         (cpuOnSubClock && !st_nxt.hsExt && !st_nxt.hsInt &&
          (st_nxt.mode == SHC_RUN || st_nxt.mode == SHC_HALT));

      // Synchronous reset overrides every field but the pin latch.
      if (rst) begin
         st_nxt.mode = SHC_RUN;
         st_nxt.stabCnt = '0;
         st_nxt.pre = '0;
         st_nxt.stabSel = `SHC_STAB_SEL_RST;
         st_nxt.hsExt = 1'b0;
         st_nxt.hsInt = 1'b1;
         st_nxt.sub = 1'b0;
         st_nxt.lowSpd = 1'b1;
         st_nxt.cpuEn = 1'b1;
         st_nxt.regLow = 1'b1;
         st_nxt.pinOut = 1'b0;
      end

      st_nxt.hold = !st_nxt.cpuEn;
   end

   // Reset is folded into the next-state logic, so one plain register holds all state.
   // state held in place
   always_ff @(posedge clock) begin
      st_r <= st_nxt;
   end

   // Every output is a bare register field, with no gate between flop and port.
   assign cpuClockEnable = st_r.cpuEn;
   assign hsExtOscEnable = st_r.hsExt;
   assign hsIntOscEnable = st_r.hsInt;
   assign subOscEnable = st_r.sub;
   assign lowSpeedOscEnable = st_r.lowSpd;
   assign regulatorLowMode = st_r.regLow;
   assign osc_stab_counter_status = st_r.stabCnt;
   assign osc_stab_time_select = st_r.stabSel;
   assign reset_output_port_pin = st_r.pinOut;
   assign standbyHold = st_r.hold;
   assign modeState = st_r.mode;
endmodule // shc_standby_ctrl
`default_nettype wire

// [verif/shc_standby_assertions.sv]
// Port assertions of the standby controller.
`timescale 1ns/10ps
`default_nettype none
module shc_standby_checker (
   // Clock, reset, requests
   input wire logic clock,
   input wire logic rst,
   input wire logic haltExec,
   input wire logic stopExec,
   input wire logic intReq,
   input wire logic cpuOnSubClock,
   input wire logic crystalSelected,
   input wire logic debugActive,
   // Outputs
   input wire logic cpuClockEnable,
   input wire logic hsExtOscEnable,
   input wire logic regulatorLowMode,
   input wire logic reset_output_port_pin,
   input wire logic standbyHold,
   input wire logic [3:0] modeState
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire logic run = modeState == 4'h1;
   wire logic stp = modeState == 4'h4;
   wire logic go = run && stopExec && !haltExec;
   property p_halt; run && haltExec |=> modeState == 4'h2 && !cpuClockEnable; endproperty
   a_halt: assert property (p_halt) else $error("halt not entered");
   property p_wake; modeState == 4'h2 && intReq |=> run && cpuClockEnable; endproperty
   a_wake: assert property (p_wake) else $error("halt not released");
   property p_stop; go && !cpuOnSubClock |=> stp && !hsExtOscEnable; endproperty
   a_stop: assert property (p_stop) else $error("stop not entered");
   property p_sub; go && cpuOnSubClock |=> run; endproperty
   a_sub: assert property (p_sub) else $error("stop taken on sub clock");
   property p_xt; stp && intReq && crystalSelected |=> modeState == 4'h8; endproperty
   a_xt: assert property (p_xt) else $error("no wait after stop");
   property p_nx; stp && intReq && !crystalSelected |=> run; endproperty
   a_nx: assert property (p_nx) else $error("stop not released");
   property p_gate; modeState == 4'h8 |-> !cpuClockEnable; endproperty
   a_gate: assert property (p_gate) else $error("clock runs in wait");
   property p_reg; stp && !$past(debugActive) |-> regulatorLowMode; endproperty
   a_reg: assert property (p_reg) else $error("regulator not low");
   property p_hold; standbyHold != cpuClockEnable; endproperty
   a_hold: assert property (p_hold) else $error("hold mismatch");
   property p_pin; disable iff (1'b0) rst |=> !reset_output_port_pin; endproperty
   a_pin: assert property (p_pin) else $error("pin high in reset");
endmodule // shc_standby_checker
`default_nettype wire

// [verif/test_shc_standby_ctrl.sv]
// Self-checking bench of the standby controller.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module test_shc_standby_ctrl;
   logic clock = 0, rst = 1, haltExec = 0, stopExec = 0, intReq = 0, cpuOnSubClock = 0;
   logic debugActive = 0, crystalSelected = 0, hsExtRunning = 1, hsIntRunning = 1;
   logic subRunning = 1, lowSpeedKeepOpt = 0, stabSelWrite = 0, resetPinLatchWrite = 0;
   logic resetPinLatchData = 0, cpuClockEnable, hsExtOscEnable, hsIntOscEnable;
   logic subOscEnable, lowSpeedOscEnable, regulatorLowMode, reset_output_port_pin;
   logic standbyHold;
   logic [2:0] stabSelData = 3'h0, osc_stab_time_select, e;
   logic [7:0] osc_stab_counter_status;
   logic [3:0] modeState;
   int mismatches = 0, comparisons = 0, n, u;
   shc_standby_ctrl #(.PRE_CYC(1)) dut_u (
      .clock(clock),
      .rst(rst),
      .haltExec(haltExec),
      .stopExec(stopExec),
      .intReq(intReq),
      .cpuOnSubClock(cpuOnSubClock),
      .debugActive(debugActive),
      .crystalSelected(crystalSelected),
      .hsExtRunning(hsExtRunning),
      .hsIntRunning(hsIntRunning),
      .subRunning(subRunning),
      .lowSpeedKeepOpt(lowSpeedKeepOpt),
      .stabSelWrite(stabSelWrite),
      .stabSelData(stabSelData),
      .resetPinLatchWrite(resetPinLatchWrite),
      .resetPinLatchData(resetPinLatchData),
      .cpuClockEnable(cpuClockEnable),
      .hsExtOscEnable(hsExtOscEnable),
      .hsIntOscEnable(hsIntOscEnable),
      .subOscEnable(subOscEnable),
      .lowSpeedOscEnable(lowSpeedOscEnable),
      .regulatorLowMode(regulatorLowMode),
      .osc_stab_counter_status(osc_stab_counter_status),
      .osc_stab_time_select(osc_stab_time_select),
      .reset_output_port_pin(reset_output_port_pin),
      .standbyHold(standbyHold),
      .modeState(modeState)
   );
   initial forever #25 clock = ~clock;
   task automatic tick(int k = 1); repeat (k) @(negedge clock); endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task t_halt;
      for (int s = 0; s < 2; s++) begin
         cpuOnSubClock = s[0];
         lowSpeedKeepOpt = s[0];
         hsExtRunning = !s[0];
         hsIntRunning = !s[0];
         tick;
         e = {hsExtRunning, hsIntRunning, subRunning};
         haltExec = 1;
         tick;
         haltExec = 0;
         tick(3);
         `CHK(modeState, 4'h2)
         `CHK(cpuClockEnable, 1'b0)
         `CHK(standbyHold, 1'b1)
         `CHK({hsExtOscEnable, hsIntOscEnable, subOscEnable}, e)
         `CHK(lowSpeedOscEnable, s[0])
         `CHK(regulatorLowMode, s[0])
         intReq = 1;
         tick;
         intReq = 0;
         `CHK(modeState, 4'h1)
         `CHK(cpuClockEnable, 1'b1)
         `CHK(standbyHold, 1'b0)
      end
      cpuOnSubClock = 0;
      lowSpeedKeepOpt = 0;
      hsExtRunning = 1;
      hsIntRunning = 1;
      $display("halt test done");
   endtask
   task t_stop;
      for (int k = 0; k < 3; k++) begin
         crystalSelected = k != 0;
         debugActive = k == 2;
         stabSelData = 3'(k);
         u = 2 ** (k + 1) - 1;
         stabSelWrite = 1;
         tick;
         stabSelWrite = 0;
         stopExec = 1;
         tick;
         stopExec = 0;
         `CHK({modeState, hsExtOscEnable, hsIntOscEnable}, 6'h10)
         `CHK(regulatorLowMode, k != 2)
         `CHK(osc_stab_time_select, 3'(k))
         `CHK(osc_stab_counter_status, 8'h00)
         intReq = 1;
         tick;
         intReq = 0;
         `CHK(modeState, k ? 4'h8 : 4'h1)
         for (n = 0; n < 200 && !cpuClockEnable; n++) tick;
         if (n == 200) begin
            mismatches++;
            print_verdict;
         end
         if (k) `CHK(n >= u - 1 && n < u + 4 && osc_stab_counter_status >= u, 1'b1)
         `CHK(osc_stab_time_select, 3'(k))
      end
      crystalSelected = 0;
      debugActive = 0;
      $display("stop test done");
   endtask
   task t_sub;
      cpuOnSubClock = 1;
      stopExec = 1;
      tick;
      stopExec = 0;
      tick;
      `CHK(modeState, 4'h1)
      `CHK(cpuClockEnable, 1'b1)
      cpuOnSubClock = 0;
      $display("sub test done");
   endtask
   task t_pin;
      resetPinLatchData = 1;
      resetPinLatchWrite = 1;
      tick;
      resetPinLatchWrite = 0;
      tick;
      `CHK(reset_output_port_pin, 1'b1)
      rst = 1;
      tick;
      `CHK({reset_output_port_pin, osc_stab_time_select, modeState}, 8'h71)
      `CHK({cpuClockEnable, hsExtOscEnable, hsIntOscEnable, regulatorLowMode}, 4'hB)
      `CHK(osc_stab_counter_status, 8'h00)
      rst = 0;
      tick;
      `CHK(reset_output_port_pin, 1'b1)
      $display("pin test done");
   endtask
   initial begin
      tick(2); rst = 0;
      t_halt; t_stop; t_sub; t_pin;
      print_verdict;
   end
endmodule // test_shc_standby_ctrl
bind shc_standby_ctrl shc_standby_checker chk_u (
   .clock(clock),
   .rst(rst),
   .haltExec(haltExec),
   .stopExec(stopExec),
   .intReq(intReq),
   .cpuOnSubClock(cpuOnSubClock),
   .crystalSelected(crystalSelected),
   .debugActive(debugActive),
   .cpuClockEnable(cpuClockEnable),
   .hsExtOscEnable(hsExtOscEnable),
   .regulatorLowMode(regulatorLowMode),
   .reset_output_port_pin(reset_output_port_pin),
   .standbyHold(standbyHold),
   .modeState(modeState)
);
`default_nettype wire
